//--- cfa_core.sv
// Card command logic: access checks, file structure gating, record pointer, auth operands.
// Operation
// - Levels: 0 always, 1 code one, 2 code two, 4-14 admin, 15 never.
// - Refuse an operation whose condition on the selected file fails.
// - Read and seek share a condition; select and status are unchecked.
// - Level 1: first code verified, disabled or unblocked this session.
// - Level 2: second code verified or unblocked this session.
// - Never-level operations are refused.
// - Levels are independent of each other.
// - A granted level lasts the session; blocking withdraws it at once.
// - A satisfied level applies in every directory.
// - Second-code commands are refused while it is uninitialized.
// - Operations only on file structures that support them.
// - Byte-string read and update only on transparent files.
// - Selection clears a linear pointer; cyclic points at record 1.
// - Status returns directory data; current file unchanged.
// - A failed record read never moves the pointer.
// - Current and absolute reads leave the pointer.
// - Undefined pointer: next reads first, previous reads last.
// - Linear next on last record fails; else pointer increments.
// - Cyclic next on last record wraps to the first.
// - Linear previous on first record fails; else pointer decrements.
// - Cyclic previous on first record wraps to the last.
// - 128-bit challenge in; 32-bit response and 64-bit key out.
// - Records number from 1, at most 255; record 1 newest.
`default_nettype none
module cfa_core
   import cfa_pkg::*;
(
   // Clock, enable and reset.
   input  wire logic                core_clk,
   input  wire logic                ce,
   input  wire logic                arst_n,
   // Register port.
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_we,
   input  wire logic                reg_re,
   output logic      [31:0]         reg_rdata,
   // Command completion and record fetch request.
   output logic                     cmd_done,
   output logic                     rec_read_req,
   output logic      [7:0]          rec_read_num,
   // Authentication function operands.
   output logic                     auth_start,
   output logic      [CHAL_W-1:0]   auth_challenge,
   input  wire logic                auth_done,
   input  wire logic [RESP_W-1:0]   auth_result
);

   typedef struct packed {
      logic [31:0]     rdata;
      cfa_cmd_s        cmd;
      cfa_fcfg_s       fcfg;
      cfa_sess_s       sess;
      cfa_status_e     status;
      logic [7:0]      rec;
      logic [15:0]     dir_fid;
      logic            ef_sel;
      logic [7:0]      ptr;
      logic            ptr_valid;
      logic [CHAL_W-1:0] chal;
      logic [RESP_W-1:0] resp;
      logic            busy;
      logic            auth_start;
      logic            rd_req;
      logic [7:0]      rd_num;
      logic            cmd_done;
   } cfa_state_s;

   cfa_state_s  st_reg;
   cfa_state_s  st_next;
   logic [1:0]  rst_sync_reg;
   logic        rst_n;

   cfa_acc_if acc ();

   cfa_acc_check u_check (
      .acc (acc.chk)
   );

   // The reset release is also held by the enable, so a frozen block stays frozen.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_reg <= 2'h0;
      end else if (ce) begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   always_comb begin
      cfa_cmd_s    cmd;
      cfa_fcfg_s   fc;
      cfa_res_s    res;
      logic        needs_ef;
      logic        struct_ok;
      logic        last_rec;
      logic        first_rec;
      logic        is_cyc;
      logic [7:0]  rec;
      logic [7:0]  new_ptr;
      logic        set_ptr;
      cfa_status_e stat;
      cmd       = cfa_cmd_s'(reg_wdata);
      fc        = st_reg.fcfg;
      res       = '0;
      needs_ef  = 1'b0;
      struct_ok = 1'b1;
      rec       = 8'h00;
      new_ptr   = st_reg.ptr;
      set_ptr   = 1'b0;
      stat      = ST_OK;
      is_cyc    = (fc.fstruct == FS_CYCLIC);
      last_rec  = (st_reg.ptr == fc.nrec);
      first_rec = (st_reg.ptr == FIRST_REC);

      st_next            = st_reg;
      st_next.rdata      = 32'h0000_0000;
      st_next.auth_start = 1'b0;
      st_next.rd_req     = 1'b0;
      st_next.cmd_done   = 1'b0;

      // Session flags are global, so a code satisfied in one directory serves all.
      acc.sess  = st_reg.sess;
      acc.level = LVL_ALWAYS;
      unique case (cmd.op)
         OP_READ_BIN: begin
            acc.level = fc.rd_ac;
            needs_ef  = 1'b1;
            struct_ok = (fc.fstruct == FS_TRANSPARENT);
         end
         OP_UPDATE_BIN: begin
            acc.level = fc.upd_ac;
            needs_ef  = 1'b1;
            struct_ok = (fc.fstruct == FS_TRANSPARENT);
         end
         OP_READ_REC, OP_UPDATE_REC: begin
            acc.level = (cmd.op == OP_READ_REC) ? fc.rd_ac : fc.upd_ac;
            needs_ef  = 1'b1;
            struct_ok = (fc.fstruct == FS_LINEAR) || is_cyc;
         end
         OP_SEEK: begin
            acc.level = fc.rd_ac;
            needs_ef  = 1'b1;
            struct_ok = (fc.fstruct == FS_LINEAR);
         end
         OP_INCREASE: begin
            acc.level = fc.inc_ac;
            needs_ef  = 1'b1;
            struct_ok = is_cyc;
         end
         default: begin
            // Select and status carry no condition at all.
            acc.level = LVL_ALWAYS;
         end
      endcase

      if (reg_we && reg_addr == OFS_CMD) begin
         st_next.cmd      = cmd;
         st_next.cmd_done = 1'b1;
         if (needs_ef && !st_reg.ef_sel) begin
            stat = ST_NO_EF;
         end else if (!struct_ok) begin
            stat = ST_BAD_STRUCT;
         end else if (!acc.granted) begin
            stat = ST_DENIED;
         end else begin
            unique case (cmd.op)
               OP_SELECT: begin
                  if (cmd.mode == SEL_ROOT) begin
                     st_next.dir_fid   = ROOT_FID;
                     st_next.ef_sel    = 1'b0;
                     st_next.ptr_valid = 1'b0;
                  end else if (cmd.mode == SEL_DIR) begin
                     st_next.dir_fid   = cmd.arg16;
                     st_next.ef_sel    = 1'b0;
                     st_next.ptr_valid = 1'b0;
                  end else if (cmd.mode == SEL_EF) begin
                     // The file description must be loaded before the selection.
                     st_next.ef_sel    = (fc.fstruct != FS_NONE);
                     st_next.ptr       = FIRST_REC;
                     st_next.ptr_valid = is_cyc;
                     stat              = (fc.fstruct != FS_NONE) ? ST_OK : ST_BAD_STRUCT;
                  end else begin
                     stat = ST_BAD_OP;
                  end
               end
               OP_STATUS: begin
                  // Directory data is read back from the directory register.
                  stat = ST_OK;
               end
               OP_READ_REC: begin
                  if (fc.nrec == 8'h00) begin
                     stat = ST_BAD_REC;
                  end else begin
                     unique case (cmd.mode)
                        MD_CURRENT: begin
                           rec  = st_reg.ptr;
                           stat = st_reg.ptr_valid ? ST_OK : ST_BAD_REC;
                        end
                        MD_ABSOLUTE: begin
                           rec  = cmd.arg8;
                           stat = (cmd.arg8 >= FIRST_REC && cmd.arg8 <= fc.nrec) ?
                                  ST_OK : ST_BAD_REC;
                        end
                        MD_NEXT: begin
                           set_ptr = 1'b1;
                           if (!st_reg.ptr_valid) begin
                              rec = FIRST_REC;
                           end else if (last_rec && !is_cyc) begin
                              stat = ST_NO_DATA;
                           end else if (last_rec) begin
                              rec = FIRST_REC;
                           end else begin
                              rec = 8'(st_reg.ptr + 8'h01);
                           end
                        end
                        MD_PREVIOUS: begin
                           set_ptr = 1'b1;
                           if (!st_reg.ptr_valid) begin
                              rec = fc.nrec;
                           end else if (first_rec && !is_cyc) begin
                              stat = ST_NO_DATA;
                           end else if (first_rec) begin
                              rec = fc.nrec;
                           end else begin
                              rec = 8'(st_reg.ptr - 8'h01);
                           end
                        end
                        default: begin
                           stat = ST_BAD_OP;
                        end
                     endcase
                  end
                  new_ptr = rec;
                  if (stat == ST_OK) begin
                     st_next.rd_req = 1'b1;
                     st_next.rd_num = rec;
                     if (set_ptr) begin
                        st_next.ptr       = new_ptr;
                        st_next.ptr_valid = 1'b1;
                     end
                  end
                  // Any failure leaves the pointer where it stood.
                  st_next.rec = (stat == ST_OK) ? rec : st_reg.rec;
               end
               OP_READ_BIN, OP_UPDATE_BIN, OP_UPDATE_REC, OP_SEEK, OP_INCREASE: begin
                  // Data movement for these is done by firmware once the gate opens.
                  stat = ST_OK;
               end
               OP_RUN_AUTH: begin
                  if (st_reg.busy) begin
                     stat = ST_BAD_OP;
                  end else begin
                     st_next.auth_start = 1'b1;
                     st_next.busy       = 1'b1;
                  end
               end
               OP_CODE2: begin
                  stat = st_reg.sess.code2_init ? ST_OK : ST_UNINIT;
               end
               default: begin
                  stat = (cmd.op == OP_NOP) ? ST_OK : ST_BAD_OP;
               end
            endcase
         end
         st_next.status = stat;
      end else if (reg_we && reg_addr == OFS_FCFG) begin
         st_next.fcfg = cfa_fcfg_s'(reg_wdata);
      end else if (reg_we && reg_addr == OFS_SESS) begin
         // Writing zeros ends the session; blocked bits take effect at once.
         st_next.sess = cfa_sess_s'(reg_wdata);
      end else if (reg_we && reg_addr[7:4] == OFS_CHAL0[7:4] && reg_addr[1:0] == 2'h0) begin
         st_next.chal[32*reg_addr[3:2] +: 32] = reg_wdata;
      end

      // The response is taken only while a run is outstanding; strays are dropped.
      if (auth_done && st_reg.busy) begin
         st_next.resp = auth_result;
         st_next.busy = 1'b0;
      end

      res.status    = st_reg.status;
      res.ptr_valid = st_reg.ptr_valid;
      res.ptr       = st_reg.ptr;
      res.rec       = st_reg.rec;
      res.busy      = st_reg.busy;
      res.ef_sel    = st_reg.ef_sel;
      if (reg_re) begin
         unique case (reg_addr)
            OFS_CMD:  st_next.rdata = st_reg.cmd;
            OFS_FCFG: st_next.rdata = st_reg.fcfg;
            OFS_SESS: st_next.rdata = st_reg.sess;
            OFS_RES:  st_next.rdata = res;
            OFS_DIR:  st_next.rdata = {8'h00, st_reg.sess[7:0], st_reg.dir_fid};
            default: begin
               if (reg_addr[7:4] == OFS_CHAL0[7:4] && reg_addr[1:0] == 2'h0) begin
                  st_next.rdata = word_of(st_reg.chal, reg_addr[3:2]);
               end else if (reg_addr[7:4] == OFS_RESP0[7:4] && reg_addr[1:0] == 2'h0
                            && reg_addr[3:2] != 2'h3) begin
                  // Word 0 is the signed response, words 1 and 2 the cipher key.
                  st_next.rdata = word_of({32'h0, st_reg.resp[31:0], st_reg.resp[63:32],
                                           st_reg.resp[RESP_W-1 -: SIGNED_RESPONSE_W]},
                                          reg_addr[3:2]);
               end else begin
                  st_next.rdata = 32'h0000_0000;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg         <= '0;
         st_reg.fcfg    <= FCFG_RST;
         st_reg.sess    <= SESS_RST;
         st_reg.dir_fid <= ROOT_FID;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata      = st_reg.rdata;
   assign cmd_done       = st_reg.cmd_done;
   assign rec_read_req   = st_reg.rd_req;
   assign rec_read_num   = st_reg.rd_num;
   assign auth_start     = st_reg.auth_start;
   assign auth_challenge = st_reg.chal;

endmodule : cfa_core
`default_nettype wire

//--- cfa_pkg.sv
// Shared constants, register layouts and command encodings of the card file access block.
`default_nettype none
package cfa_pkg;

   // Register offsets on the plain register port.
   localparam logic [7:0] OFS_CMD   = 8'h00;
   localparam logic [7:0] OFS_FCFG  = 8'h04;
   localparam logic [7:0] OFS_SESS  = 8'h08;
   localparam logic [7:0] OFS_RES   = 8'h0c;
   localparam logic [7:0] OFS_DIR   = 8'h10;
   localparam logic [7:0] OFS_CHAL0 = 8'h20;
   localparam logic [7:0] OFS_RESP0 = 8'h30;

   // Access condition levels.
   localparam logic [3:0] LVL_ALWAYS = 4'h0;
   localparam logic [3:0] LVL_CODE1  = 4'h1;
   localparam logic [3:0] LVL_CODE2  = 4'h2;
   localparam logic [3:0] LVL_RSV    = 4'h3;
   localparam logic [3:0] LVL_ADM_LO = 4'h4;
   localparam logic [3:0] LVL_ADM_HI = 4'he;
   localparam logic [3:0] LVL_NEVER  = 4'hf;

   // Authentication operand sizes.
   localparam int unsigned CHAL_W = 128;
   localparam int unsigned RESP_W = 96;
   localparam int unsigned SIGNED_RESPONSE_W = 32;
   localparam int unsigned KEY_W  = 64;

   localparam logic [15:0] ROOT_FID  = 16'h3f00;
   localparam logic [7:0]  FIRST_REC = 8'h01;

   typedef enum logic [3:0] {
      OP_NOP        = 4'h0,
      OP_SELECT     = 4'h1,
      OP_STATUS     = 4'h2,
      OP_READ_BIN   = 4'h3,
      OP_UPDATE_BIN = 4'h4,
      OP_READ_REC   = 4'h5,
      OP_UPDATE_REC = 4'h6,
      OP_SEEK       = 4'h7,
      OP_INCREASE   = 4'h8,
      OP_RUN_AUTH   = 4'h9,
      OP_CODE2      = 4'ha
   } cfa_op_e;

   // Record modes; for a selection the same field holds the kind of file selected.
   typedef enum logic [2:0] {
      MD_CURRENT  = 3'h0,
      MD_ABSOLUTE = 3'h1,
      MD_NEXT     = 3'h2,
      MD_PREVIOUS = 3'h3
   } cfa_mode_e;
   localparam logic [2:0] SEL_ROOT = 3'h0;
   localparam logic [2:0] SEL_DIR  = 3'h1;
   localparam logic [2:0] SEL_EF   = 3'h2;

   typedef enum logic [1:0] {
      FS_TRANSPARENT = 2'h0,
      FS_LINEAR      = 2'h1,
      FS_CYCLIC      = 2'h2,
      FS_NONE        = 2'h3
   } cfa_fstruct_e;

   typedef enum logic [3:0] {
      ST_OK         = 4'h0,
      ST_DENIED     = 4'h1,
      ST_BAD_STRUCT = 4'h2,
      ST_NO_DATA    = 4'h3,
      ST_BAD_REC    = 4'h4,
      ST_NO_EF      = 4'h5,
      ST_UNINIT     = 4'h6,
      ST_BAD_OP     = 4'h7
   } cfa_status_e;

   typedef struct packed {
      logic [15:0] arg16;
      logic [7:0]  arg8;
      logic        rsv;
      logic [2:0]  mode;
      cfa_op_e     op;
   } cfa_cmd_s;

   typedef struct packed {
      logic [3:0]   rsv_hi;
      logic [3:0]   inc_ac;
      logic [3:0]   upd_ac;
      logic [3:0]   rd_ac;
      logic [7:0]   nrec;
      logic [5:0]   rsv_lo;
      cfa_fstruct_e fstruct;
   } cfa_fcfg_s;

   typedef struct packed {
      logic [12:0] rsv;
      logic [10:0] adm_mask;
      logic        code2_init;
      logic        code2_blocked;
      logic        code1_blocked;
      logic        code2_unblocked;
      logic        code2_verified;
      logic        code1_unblocked;
      logic        code1_disabled;
      logic        code1_verified;
   } cfa_sess_s;

   typedef struct packed {
      logic [5:0]  rsv_hi;
      logic        ef_sel;
      logic        busy;
      logic [7:0]  rec;
      logic [7:0]  ptr;
      logic [2:0]  rsv_lo;
      logic        ptr_valid;
      cfa_status_e status;
   } cfa_res_s;

   localparam cfa_fcfg_s FCFG_RST = cfa_fcfg_s'(32'h0fff_0003);
   localparam cfa_sess_s SESS_RST = cfa_sess_s'(32'h0000_0000);

   function automatic logic [31:0] word_of(input logic [127:0] v, input logic [1:0] i);
      word_of = v[32*i +: 32];
   endfunction : word_of

endpackage : cfa_pkg
`default_nettype wire

//--- cfa_acc_if.sv
// Interface between the command logic and the access condition checker.
`default_nettype none
interface cfa_acc_if;
   import cfa_pkg::*;
   logic [3:0] level;
   cfa_sess_s  sess;
   logic       granted;
   modport chk (input level, input sess, output granted);
   modport req (output level, output sess, input granted);
endinterface : cfa_acc_if
`default_nettype wire

//--- cfa_acc_check.sv
// Access condition checker: decides whether one condition level is fulfilled.
`default_nettype none
module cfa_acc_check
   import cfa_pkg::*;
(
   // Level and session flags in, verdict out.
   cfa_acc_if.chk acc
);
   always_comb begin
      acc.granted = 1'b0;
      if (acc.level == LVL_ALWAYS) begin
         acc.granted = 1'b1;
      end else if (acc.level == LVL_CODE1) begin
         // A blocked code withdraws whatever it granted, at once.
         acc.granted = (acc.sess.code1_verified | acc.sess.code1_disabled
                        | acc.sess.code1_unblocked) & ~acc.sess.code1_blocked;
      end else if (acc.level == LVL_CODE2) begin
         acc.granted = (acc.sess.code2_verified | acc.sess.code2_unblocked)
                       & ~acc.sess.code2_blocked;
      end else if (acc.level >= LVL_ADM_LO && acc.level <= LVL_ADM_HI) begin
         acc.granted = acc.sess.adm_mask[4'(acc.level - LVL_ADM_LO)];
      end else begin
         // Reserved and never levels are always refused by the checker.
         acc.granted = 1'b0;
      end
   end
endmodule : cfa_acc_check
`default_nettype wire

//--- cfa_auth_model.sv
// Behavioural authentication function that answers the card's start pulse.
`default_nettype none
module cfa_auth_model
   import cfa_pkg::*;
(
   // Clock and reset.
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   // Request from the card and the answer to it.
   input  wire logic              auth_start,
   input  wire logic [CHAL_W-1:0] auth_challenge,
   output logic                   auth_done,
   output logic      [RESP_W-1:0] auth_result
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]        wait_reg;
   logic [CHAL_W-1:0] chal_reg;
   // Latency follows the low challenge bits, so quick and slow answers both occur.
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg <= 4'h0;
         auth_done <= 1'b0;
         auth_result <= '0;
      end else begin
         auth_done <= 1'b0;
         auth_result <= ~auth_result;
         if (auth_start) begin
            wait_reg <= 4'h1 + {1'b0, auth_challenge[2:0]};
            chal_reg <= auth_challenge;
         end else if (wait_reg == 4'h1) begin
            auth_done <= 1'b1;
            auth_result <= {chal_reg[127:96] ^ chal_reg[31:0], chal_reg[95:32]};
            wait_reg <= 4'h0;
         end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
         end
      end
   end
endmodule : cfa_auth_model
`default_nettype wire

//--- cfa_core_chk.sv
// Port-level assertions for the card command logic.
`default_nettype none
module cfa_core_chk
   import cfa_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              ce,
   input wire logic              arst_n,
   input wire logic [7:0]        reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_we,
   input wire logic              reg_re,
   input wire logic [31:0]       reg_rdata,
   input wire logic              cmd_done,
   input wire logic              rec_read_req,
   input wire logic [7:0]        rec_read_num,
   input wire logic              auth_start,
   input wire logic [CHAL_W-1:0] auth_challenge,
   input wire logic              auth_done,
   input wire logic [RESP_W-1:0] auth_result
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence cmd_wr_s;
      ce && reg_we && reg_addr == OFS_CMD;
   endsequence
   sequence read_abs_s;
      cmd_wr_s ##0 (reg_wdata[3:0] == OP_READ_REC && reg_wdata[6:4] == MD_ABSOLUTE);
   endsequence
   done_after_cmd_a: assert property (cmd_wr_s |=> cmd_done)
      else $error("no cmd_done after command");
   done_cause_a: assert property (cmd_done |-> $past(ce && reg_we && reg_addr == OFS_CMD))
      else $error("stray cmd_done");
   req_with_done_a: assert property (rec_read_req |-> cmd_done)
      else $error("fetch outside completion");
   nonread_noreq_a: assert property (
      cmd_wr_s ##0 (reg_wdata[3:0] != OP_READ_REC) |=> !rec_read_req)
      else $error("fetch for a non-read command");
   abs_num_a: assert property (
      read_abs_s ##1 rec_read_req |-> rec_read_num == $past(reg_wdata[15:8]))
      else $error("wrong absolute record");
   num_hold_a: assert property (!rec_read_req |-> $stable(rec_read_num))
      else $error("record number moved");
   rdata_idle_a: assert property (!$past(ce && reg_re) |-> reg_rdata == 32'h0)
      else $error("read data not zero");
   auth_cause_a: assert property (
      auth_start |-> $past(ce && reg_we && reg_addr == OFS_CMD && reg_wdata[3:0] == OP_RUN_AUTH))
      else $error("stray auth_start");
   auth_pulse_a: assert property (auth_start |=> !auth_start)
      else $error("auth_start too long");
endmodule : cfa_core_chk
bind cfa_core cfa_core_chk chk_i (.*);
`default_nettype wire

//--- cfa_core_tb_top.sv
// Self-checking bench for the card command logic with an authentication model.
`default_nettype none
module cfa_core_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cfa_pkg::*;
   logic              core_clk, ce, arst_n, reg_we, reg_re, cmd_done, rec_read_req;
   logic              auth_start, auth_done, v;
   logic [7:0]        reg_addr, rec_read_num, ptr, n, num;
   logic [31:0]       reg_wdata, reg_rdata, d, sess;
   logic [CHAL_W-1:0] auth_challenge, chal;
   logic [RESP_W-1:0] auth_result;
   logic [20:0]       e;
   logic [3:0]        lvl;
   logic [2:0]        md;
   cfa_res_s          res;
   int                fails, n_compared, seed, i, k;
   cfa_core uut (.*);
   cfa_auth_model far_i (.*);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] w);
      reg_addr <= a;
      reg_wdata <= w;
      reg_we <= 1'b1;
      @(posedge core_clk);
      reg_we <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task rd(input logic [7:0] a);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge core_clk);
      reg_re <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
      @(posedge core_clk);
   endtask : rd
   // Each command is followed by a read of the result register.
   task cmd(input logic [3:0] op, input logic [2:0] m, input logic [7:0] a8,
            input logic [15:0] a16);
      wr(OFS_CMD, {a16, a8, 1'b0, m, op});
      rd(OFS_RES);
      res = cfa_res_s'(d);
   endtask : cmd
   task test_done;
      $display("Comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   function automatic logic grant(input logic [3:0] l, input logic [31:0] s);
      case (l)
         LVL_ALWAYS: return 1'b1;
         LVL_CODE1: return !s[5] && (s[0] || s[1] || s[2]);
         LVL_CODE2: return !s[6] && (s[3] || s[4]);
         LVL_RSV, LVL_NEVER: return 1'b0;
         default: return s[int'(l) + 4];
      endcase
   endfunction : grant
   // Packs status, pointer flag, pointer and record expected after one record read.
   function automatic logic [20:0] exp_rd(input logic cy, input logic [7:0] n, p, num,
                                          input logic v, input logic [2:0] m);
      logic [7:0] t;
      logic       ok;
      ok = (n != 8'h00);
      t = p;
      case (m)
         MD_CURRENT: ok = ok && v;
         MD_ABSOLUTE: begin
            ok = ok && num != 8'h00 && num <= n;
            t = num;
         end
         MD_NEXT: t = !v ? 8'h01 : (p != n) ? p + 8'h01 : cy ? 8'h01 : 8'h00;
         default: t = !v ? n : (p != 8'h01) ? p - 8'h01 : cy ? n : 8'h00;
      endcase
      if (!ok) return {ST_BAD_REC, v, p, 8'h00};
      if (t == 8'h00) return {ST_NO_DATA, v, p, 8'h00};
      if (m == MD_CURRENT || m == MD_ABSOLUTE) return {ST_OK, v, p, t};
      return {ST_OK, 1'b1, t, t};
   endfunction : exp_rd
   initial begin
      seed = 73;
      ce = 1'b1;
      fails = 0;
      n_compared = 0;
      arst_n = 1'b0;
      reg_we = 1'b0;
      reg_re = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(OFS_FCFG);
      chk(d, 32'h0fff_0003);
      rd(OFS_DIR);
      chk(d[15:0], ROOT_FID);
      rd(8'h50);
      chk(d, 32'h0);
      for (k = 0; k < 24; k++) begin
         lvl = (k < 16) ? 4'(k) : 4'($unsigned($random(seed)) % 3);
         sess = $random(seed) & 32'h0007_ffff;
         wr(OFS_SESS, sess);
         wr(OFS_FCFG, {12'h000, lvl, 8'h02, 6'h00, FS_LINEAR});
         cmd(OP_SELECT, SEL_DIR, 8'h00, k[0] ? 16'h7f10 : 16'h7f20);
         cmd(OP_SELECT, SEL_EF, 8'h00, 16'h6f3a);
         chk(res.status, ST_OK);
         cmd(OP_READ_REC, MD_ABSOLUTE, 8'h01, 16'h0000);
         chk(res.status, grant(lvl, sess) ? ST_OK : ST_DENIED);
         cmd(OP_SEEK, MD_NEXT, 8'h01, 16'h0000);
         chk(res.status, grant(lvl, sess) ? ST_OK : ST_DENIED);
      end
      cmd(OP_SELECT, SEL_DIR, 8'h00, 16'h7f20);
      for (i = 0; i < 3; i++) begin
         wr(OFS_FCFG, {16'h0000, 8'h04, 6'h00, 2'(i)});
         cmd(OP_SELECT, SEL_EF, 8'h00, 16'h6f3a);
         for (k = 3; k < 9; k++) begin
            cmd(4'(k), MD_PREVIOUS, 8'h01, 16'h0000);
            v = (k < 5) ? (i == 0) : (k < 7) ? (i != 0) : (k == 7) ? (i == 1) : (i == 2);
            chk(res.status, v ? ST_OK : ST_BAD_STRUCT);
         end
      end
      cmd(OP_STATUS, 3'h0, 8'h00, 16'h0000);
      chk({res.ef_sel, res.status}, {1'b1, ST_OK});
      rd(OFS_DIR);
      chk(d[15:0], 16'h7f20);
      cmd(OP_SELECT, SEL_ROOT, 8'h00, ROOT_FID);
      cmd(OP_READ_REC, MD_CURRENT, 8'h00, 16'h0000);
      chk(res.status, ST_NO_EF);
      wr(OFS_SESS, 32'h0);
      cmd(OP_CODE2, 3'h0, 8'h00, 16'h0000);
      chk(res.status, ST_UNINIT);
      wr(OFS_SESS, 32'h80);
      cmd(OP_CODE2, 3'h0, 8'h00, 16'h0000);
      chk(res.status, ST_OK);
      for (k = 0; k < 12; k++) begin
         v = k[0];
         n = (k == 11) ? 8'hff : 8'($unsigned($random(seed)) % 4) + {7'h00, v};
         wr(OFS_FCFG, {16'h0000, n, 6'h00, v ? FS_CYCLIC : FS_LINEAR});
         cmd(OP_SELECT, SEL_EF, 8'h00, 16'h6f3a);
         ptr = 8'h01;
         chk({res.ptr_valid, res.ptr & {8{v}}}, {v, 7'h00, v});
         for (i = 0; i < 10; i++) begin
            md = 3'($unsigned($random(seed)) % 4);
            num = 8'($unsigned($random(seed)) % 6);
            cmd(OP_READ_REC, md, num, 16'h0000);
            e = exp_rd(k[0], n, ptr, num, v, md);
            chk({res.status, res.ptr_valid}, e[20:16]);
            if (e[16]) chk(res.ptr, e[15:8]);
            if (e[20:17] == ST_OK) chk(res.rec, e[7:0]);
            v = e[16];
            ptr = e[15:8];
         end
      end
      for (k = 0; k < 3; k++) begin
         chal = {$random(seed), $random(seed), $random(seed), $random(seed)};
         if (k == 0) chal[2:0] = 3'h7;
         for (i = 0; i < 4; i++) wr(OFS_CHAL0 + 8'(4 * i), chal[32 * i +: 32]);
         cmd(OP_RUN_AUTH, 3'h0, 8'h00, 16'h0000);
         if (k == 0) cmd(OP_RUN_AUTH, 3'h0, 8'h00, 16'h0000);
         chk(res.status, (k == 0) ? ST_BAD_OP : ST_OK);
         for (i = 0; i < 30 && res.busy !== 1'b0; i++) cmd(OP_NOP, 3'h0, 8'h00, 16'h0000);
         for (i = 0; i < 3; i++) begin
            rd(OFS_RESP0 + 8'(4 * i));
            chk(d, {chal[127:96] ^ chal[31:0], chal[95:32]} >> (64 - 32 * i));
         end
      end
      test_done();
   end
   initial begin
      #(100 * 20000);
      fails++;
      test_done();
   end
endmodule : cfa_core_tb_top
`default_nettype wire
